// [dssd_pkg.sv]
// Package for the dual-slope sequencer and display block.
// Assumes one clock domain; all users refer to names as dssd_pkg::name.
package dssd_pkg;
  localparam int CLK_DIV = 4;
  localparam int INT_COUNTS = 1000;
  localparam int DEINT_MAX = 2000;
  localparam int CYCLE_COUNTS = 4000;
  localparam int BP_DIV = 4800;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [1:0] DIV_ZERO = 2'h0;
  localparam logic [1:0] DIV_LAST = 2'h3;
  localparam logic [6:0] SEG_ALL = 7'h7F;
  localparam logic [6:0] SEG_OFF = 7'h00;
  localparam logic [6:0] SEG_ONE = 7'h06;
  typedef enum logic [2:0] {
    DSSD_ZERO = 3'h1,
    DSSD_INT = 3'h2,
    DSSD_DEINT = 3'h4
  } dssd_phase_t;
endpackage

// [dssd_core.sv]
// Dual-slope converter sequencer with seven-segment LCD/LED drive.
// Assumes comparator and hold/test pins are asynchronous and come from outside.
`timescale 1ns/1ps
module dssd_core #(
  parameter int CYCLE_CLKS = dssd_pkg::CYCLE_COUNTS * dssd_pkg::CLK_DIV,
  parameter int BP_HALF = dssd_pkg::BP_DIV / 2
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic comp_in,
  input wire logic display_hold_request_in,
  input wire logic seg_check_in,
  input wire logic lcd_mode_in,
  output logic zero_offset_phase_out,
  output logic integrate_phase_out,
  output logic deintegrate_phase_out,
  output logic ref_negative_out,
  output logic backplane_drive_out,
  output logic [6:0] seg_ones_out,
  output logic [6:0] seg_tens_out,
  output logic [6:0] seg_hund_out,
  output logic [1:0] seg_thou_out,
  output logic seg_sign_out,
  output logic over_range_out
);
  localparam int BPW = $clog2(BP_HALF + 1);

  function automatic logic [6:0] seg7(input logic [3:0] d);
    unique case (d)
      4'h0: seg7 = 7'h3F;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5B;
      4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6D;
      4'h6: seg7 = 7'h7D;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;
      4'h9: seg7 = 7'h6F;
      default: seg7 = 7'h00;
    endcase
  endfunction

  // Comparator, hold and check pins: three-stage sync, change on agreement
  logic [2:0] comp_s, hold_s, chk_s;
  logic comp_q, hold_q, chk_q;
  logic next_comp_q, next_hold_q, next_chk_q;
  always_comb
  begin
    next_comp_q = (comp_s[1] == comp_s[2]) ? comp_s[1] : comp_q;
    next_hold_q = (hold_s[1] == hold_s[2]) ? hold_s[1] : hold_q;
    next_chk_q = (chk_s[1] == chk_s[2]) ? chk_s[1] : chk_q;
  end
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      comp_s <= 3'h0;
      hold_s <= 3'h0;
      chk_s <= 3'h0;
      comp_q <= 1'b0;
      hold_q <= 1'b0;
      chk_q <= 1'b0;
    end
    else
    begin
      comp_s <= {comp_s[1:0], comp_in};
      hold_s <= {hold_s[1:0], display_hold_request_in};
      chk_s <= {chk_s[1:0], seg_check_in};
      comp_q <= next_comp_q;
      hold_q <= next_hold_q;
      chk_q <= next_chk_q;
    end
  end

  // Sequencer
  dssd_pkg::dssd_phase_t phase, next_phase;
  logic [1:0] div, next_div;
  logic [dssd_pkg::CNT_W-1:0] cnt, next_cnt, dcnt, next_dcnt, latch, next_latch;
  logic sign, next_sign, lsign, next_lsign, ovr, next_ovr, lovr, next_lovr;
  logic tick, cycle_end;
  always_comb
  begin
    tick = (div == dssd_pkg::DIV_LAST);
    next_div = div + 2'h1;
    next_phase = phase;
    next_cnt = cnt;
    next_dcnt = dcnt;
    next_sign = sign;
    next_ovr = ovr;
    next_latch = latch;
    next_lsign = lsign;
    next_lovr = lovr;
    cycle_end = 1'b0;
    if (tick)
    begin
      next_cnt = cnt + dssd_pkg::CNT_ONE;
      unique case (phase)
        dssd_pkg::DSSD_INT:
          if (cnt == dssd_pkg::CNT_W'(dssd_pkg::INT_COUNTS - 1))
          begin
            next_sign = comp_q;
            next_phase = dssd_pkg::DSSD_DEINT;
            next_dcnt = dssd_pkg::CNT_ZERO;
            next_ovr = 1'b0;
          end
        dssd_pkg::DSSD_DEINT:
        begin
          // Every tick spent here is a count, the one that sees zero too
          next_dcnt = dcnt + dssd_pkg::CNT_ONE;
          // First tick still sees the integrate level through the synchroniser
          if (!comp_q && (dcnt != dssd_pkg::CNT_ZERO))
            next_phase = dssd_pkg::DSSD_ZERO;
          else if (dcnt == dssd_pkg::CNT_W'(dssd_pkg::DEINT_MAX - 1))
          begin
            next_ovr = 1'b1;
            next_phase = dssd_pkg::DSSD_ZERO;
          end
        end
        dssd_pkg::DSSD_ZERO:
          if (cnt == dssd_pkg::CNT_W'(dssd_pkg::CYCLE_COUNTS - 1))
          begin
            cycle_end = 1'b1;
            next_cnt = dssd_pkg::CNT_ZERO;
            next_phase = dssd_pkg::DSSD_INT;
          end
        default: next_phase = dssd_pkg::DSSD_ZERO;
      endcase
      if (cycle_end && !hold_q)
      begin
        next_latch = dcnt;
        next_lsign = sign;
        next_lovr = ovr;
      end
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase <= dssd_pkg::DSSD_ZERO;
      div <= dssd_pkg::DIV_ZERO;
      cnt <= dssd_pkg::CNT_ZERO;
      dcnt <= dssd_pkg::CNT_ZERO;
      latch <= dssd_pkg::CNT_ZERO;
      sign <= 1'b0;
      lsign <= 1'b0;
      ovr <= 1'b0;
      lovr <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      div <= next_div;
      cnt <= next_cnt;
      dcnt <= next_dcnt;
      latch <= next_latch;
      sign <= next_sign;
      lsign <= next_lsign;
      ovr <= next_ovr;
      lovr <= next_lovr;
    end
  end

  // Backplane divider
  logic [BPW-1:0] bpc, next_bpc;
  logic bp, next_bp;
  always_comb
  begin
    next_bpc = bpc + BPW'(1);
    next_bp = bp;
    if (bpc == BPW'(BP_HALF - 1))
    begin
      next_bpc = '0;
      next_bp = ~bp;
    end
  end

  // Decode and drive; outputs registered
  logic [3:0] d_ones, d_tens, d_hund;
  logic [6:0] p_ones, p_tens, p_hund;
  logic [1:0] p_thou;
  logic p_sign;
  logic [6:0] next_o1, next_o10, next_o100;
  logic [1:0] next_o1000;
  logic next_osign;
  always_comb
  begin
    d_ones = 4'(latch % 10);
    d_tens = 4'((latch / 10) % 10);
    d_hund = 4'((latch / 100) % 10);
    p_ones = seg7(d_ones);
    p_tens = seg7(d_tens);
    p_hund = seg7(d_hund);
    p_thou = (latch >= dssd_pkg::CNT_W'(1000)) ? 2'h3 : 2'h0;
    // Minus lit for a negative reading, and during the segment check
    p_sign = !lsign;
    if (chk_q)
    begin
      p_ones = dssd_pkg::SEG_ALL;
      p_tens = dssd_pkg::SEG_ALL;
      p_hund = dssd_pkg::SEG_ALL;
      p_thou = 2'h3;
      p_sign = 1'b1;
    end
    // LCD: on segments inverted to backplane; LED: high means sink on
    next_o1 = lcd_mode_in ? (p_ones ^ {7{next_bp}}) : p_ones;
    next_o10 = lcd_mode_in ? (p_tens ^ {7{next_bp}}) : p_tens;
    next_o100 = lcd_mode_in ? (p_hund ^ {7{next_bp}}) : p_hund;
    next_o1000 = lcd_mode_in ? (p_thou ^ {2{next_bp}}) : p_thou;
    next_osign = lcd_mode_in ? (p_sign ^ next_bp) : p_sign;
  end
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bpc <= '0;
      bp <= 1'b0;
      seg_ones_out <= dssd_pkg::SEG_OFF;
      seg_tens_out <= dssd_pkg::SEG_OFF;
      seg_hund_out <= dssd_pkg::SEG_OFF;
      seg_thou_out <= 2'h0;
      seg_sign_out <= 1'b0;
      backplane_drive_out <= 1'b0;
    end
    else
    begin
      bpc <= next_bpc;
      bp <= next_bp;
      seg_ones_out <= next_o1;
      seg_tens_out <= next_o10;
      seg_hund_out <= next_o100;
      seg_thou_out <= next_o1000;
      seg_sign_out <= next_osign;
      backplane_drive_out <= lcd_mode_in & next_bp;
    end
  end

  assign zero_offset_phase_out = (phase == dssd_pkg::DSSD_ZERO);
  assign integrate_phase_out = (phase == dssd_pkg::DSSD_INT);
  assign deintegrate_phase_out = (phase == dssd_pkg::DSSD_DEINT);
  assign ref_negative_out = sign;
  assign over_range_out = lovr;
endmodule // dssd_core

// [dssd_core_assertions.sv]
// Port checker for the converter core: phase timing, backplane and hold.
// Assumes one clock mclk_in and reset rst_in; bound onto every core below.
`timescale 1ns/1ps
module dssd_core_checker (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic display_hold_request_in,
  input wire logic seg_check_in,
  input wire logic lcd_mode_in,
  input wire logic zero_offset_phase_out,
  input wire logic integrate_phase_out,
  input wire logic deintegrate_phase_out,
  input wire logic backplane_drive_out,
  input wire logic [6:0] seg_ones_out
);
  logic [14:0] cnt;
  logic seen;
  // Clocks since integrate began; first cycle after reset is partial
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in)
    begin
      cnt <= 15'h0000;
      seen <= 1'h0;
    end
    else
    begin
      cnt <= $rose(integrate_phase_out) ? 15'h0001 : cnt + 15'h0001;
      seen <= seen | $rose(integrate_phase_out);
    end
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  chk_int_len: assert property ($fell(integrate_phase_out) |-> cnt == 15'h0FA0)
    else $error("bad integrate length");
  chk_cycle_len: assert property ($rose(integrate_phase_out) && seen |-> cnt == 15'h3E80)
    else $error("bad cycle length");
  chk_deint_max: assert property (deintegrate_phase_out |-> cnt < 15'h2EE0)
    else $error("deintegrate too long");
  chk_phase_order: assert property ($fell(integrate_phase_out) |-> deintegrate_phase_out)
    else $error("integrate not followed by deintegrate");
  chk_deint_end: assert property ($fell(deintegrate_phase_out) |->
    zero_offset_phase_out && cnt[1:0] == 2'h0) else $error("bad deintegrate end");
  chk_led_no_bp: assert property ((!lcd_mode_in) [*3] |-> !backplane_drive_out)
    else $error("backplane active in LED mode");
  chk_lamp_test: assert property ((seg_check_in && !lcd_mode_in) [*6] |->
    seg_ones_out == 7'h7F) else $error("segment check not all on");
  chk_hold_freeze: assert property ((display_hold_request_in && !seg_check_in) [*7] |->
    $stable(seg_ones_out) || lcd_mode_in) else $error("display changed under hold");
endmodule // dssd_core_checker
bind dssd_core dssd_core_checker chk_u (.mclk_in, .rst_in, .display_hold_request_in,
  .seg_check_in, .lcd_mode_in, .zero_offset_phase_out, .integrate_phase_out,
  .deintegrate_phase_out, .backplane_drive_out, .seg_ones_out);

// [dssd_integ_model.sv]
// Integrator and comparator stand-in driving the core's comparator input.
// Assumes the core's phase outputs; target count set by the bench.
`timescale 1ns/1ps
module dssd_integ_model (
  input wire logic clk_in,
  input wire logic int_in,
  input wire logic deint_in,
  input wire logic pol_in,
  input wire logic [11:0] target_in,
  output logic comp_out
);
  int n;
  always_ff @(posedge clk_in)
    n <= deint_in ? n + 1 : 0;
  // Ramp returns to zero after target counts of four clocks each
  assign comp_out = int_in ? pol_in : deint_in && n < 4 * target_in;
endmodule // dssd_integ_model

// [testbench.sv]
// Bench for the converter core: readings, hold, lamp test, LCD phasing.
// Assumes the comparator stand-in and port checker are compiled with it.
`timescale 1ns/1ps
module testbench;
  logic mclk_in = 1'h0;
  logic rst_in = 1'h1;
  logic display_hold_request_in = 1'h0;
  logic seg_check_in = 1'h0;
  logic lcd_mode_in = 1'h0;
  logic pol = 1'h0;
  logic [11:0] tgt = 12'h000;
  logic comp_in, zero_offset_phase_out, integrate_phase_out, deintegrate_phase_out;
  logic ref_negative_out, backplane_drive_out, seg_sign_out, over_range_out;
  logic [6:0] seg_ones_out, seg_tens_out, seg_hund_out;
  logic [1:0] seg_thou_out;
  logic [6:0] pat [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  // Rows: target, polarity, hold, over range; third overruns, fourth is held
  logic [11:0] row_tgt [4] = '{12'h078, 12'h596, 12'h834, 12'h230};
  logic [3:0] row_pol = 4'h5;
  logic [3:0] row_hold = 4'h8;
  logic [3:0] row_ovr = 4'hC;
  int n_mismatch = 0;
  int num_checks = 0;
  int ncyc = 0;
  int dcnt = 0;
  int n;
  int shown = 0;
  logic shown_pol = 1'h0;
  time t;
  dssd_core #(.BP_HALF(8)) dut_u (.*);
  dssd_integ_model integ_u (.clk_in(mclk_in), .int_in(integrate_phase_out),
    .deint_in(deintegrate_phase_out), .pol_in(pol), .target_in(tgt), .comp_out(comp_in));
  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
    forever #4 mclk_in = ~mclk_in;
  // Run is five measure cycles of 16000 clocks
  always @(posedge mclk_in)
  begin
    ncyc++;
    dcnt += deintegrate_phase_out;
    if (ncyc == 90000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'h0;
    @(posedge integrate_phase_out);
    for (int i = 0; i < 4; i++)
    begin
      tgt <= row_tgt[i];
      pol <= row_pol[i];
      display_hold_request_in <= row_hold[i];
      dcnt = 0;
      @(posedge integrate_phase_out);
      repeat (4) @(posedge mclk_in);
      n = dcnt / 4;
      check(n >= (i == 2 ? 2000 : row_tgt[i]) && n <= row_tgt[i] + 2, 1'h1);
      check(over_range_out, row_ovr[i]);
      check(ref_negative_out, row_pol[i]);
      // A held cycle keeps showing the last loaded reading and sign
      if (!row_hold[i])
      begin
        shown = n;
        shown_pol = row_pol[i];
      end
      check({seg_thou_out, seg_hund_out, seg_tens_out, seg_ones_out, seg_sign_out},
        {shown > 999 ? 2'h3 : 2'h0, pat[shown / 100 % 10], pat[shown / 10 % 10],
        pat[shown % 10], !shown_pol});
    end
    seg_check_in <= 1'h1;
    repeat (6) @(posedge mclk_in);
    check({seg_thou_out, seg_hund_out, seg_tens_out, seg_ones_out, seg_sign_out,
      backplane_drive_out}, 25'h1FFFFFE);
    lcd_mode_in <= 1'h1;
    // First change may only be the enable; time from a true toggle
    @(backplane_drive_out);
    @(backplane_drive_out);
    t = $time;
    repeat (2)
    begin
      repeat (2) @(posedge mclk_in);
      check({seg_ones_out, seg_sign_out}, {8{~backplane_drive_out}});
      @(backplane_drive_out);
      check(($time - t) / 8, 8);
      t = $time;
    end
    stop_test();
  end
endmodule // testbench
